/* logic/spdx_regs.svh */
// Register indices, field positions and reset values of the receiver control block.
`ifndef SPDX_REGS_SVH
`define SPDX_REGS_SVH
// Register indices; the APB byte address is four times the index.
`define SPDX_IDX_RESTART   16'hf604
`define SPDX_IDX_LOSS      16'hf605
`define SPDX_IDX_RXSPD     16'hf606
`define SPDX_IDX_TXSPD     16'hf607
`define SPDX_IDX_AUXEN     16'hf608
// Field positions.
`define SPDX_CTL_BIT       0
`define SPDX_CLKSRC_BIT    4
`define SPDX_SEL_HI        3
`define SPDX_SEL_LO        0
`define SPDX_STRB_LO       0
// Reset values.
`define SPDX_RST_RESUME    1'b0
`define SPDX_RST_RXSPD     1'b1
`define SPDX_RST_TXSPD     1'b1
`define SPDX_RST_SEL       4'h0
`define SPDX_RST_CLKSRC    1'b0
`define SPDX_ZERO16        16'h0000
// Output port select codes.
`define SPDX_PORT_OFF      4'h0
`define SPDX_PORT0         4'h1
`define SPDX_PORT1         4'h2
`define SPDX_PORT2         4'h4
`define SPDX_PORT3         4'h8
// Eight-slot stream layout.
`define SPDX_PAD8          8'h00
`define SPDX_Z20           20'h00000
`define SPDX_Z22           22'h000000
`define SPDX_Z23           23'h000000
`define SPDX_Z32           32'h00000000
`define SPDX_FRAME_TOP     8'hff
`define SPDX_IDX_ONE       8'h01
`endif

/* logic/spdx_pkg.sv */
// Types shared by the receiver control block and its slot serializer.
package spdx_pkg;
   typedef enum logic [1:0] {SPDX_ACQUIRE, SPDX_PLAY, SPDX_MUTED} spdx_lock_st_t;

   typedef struct packed {
      spdx_lock_st_t st;
      logic          auto_resume;
      logic          lock_lost_flag;
      logic          rx_clk_div_sel;
      logic          tx_clk_div_sel;
      logic [3:0]    aux_port_select;
      logic          aux_port_clk_source;
      logic          pready;
      logic [15:0]   prdata;
      logic          pslverr;
      logic          div_phase;
      logic          rx_tick;
      logic          tx_tick;
      logic          muted;
      logic [3:0]    serial_out;
      logic [3:0]    bclk_out;
      logic [3:0]    lrclk_out;
   } spdx_ctrl_t;

   typedef struct packed {
      logic          bclk_s1;
      logic          bclk_s2;
      logic          bclk_d;
      logic          lr_s1;
      logic          lr_s2;
      logic          lr_d;
      logic [7:0]    idx;
      logic [255:0]  frame;
      logic          sdata;
   } spdx_ser_t;
endpackage

/* logic/spdx_slot_ser.sv */
// Eight-slot serializer clocked by a sampled external bit clock and frame clock.
`timescale 1ns/10ps
`include "spdx_regs.svh"

module spdx_slot_ser (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         bclk_in,
   input  wire logic         lrclk_in,
   input  wire logic         enable,
   input  wire logic [255:0] frame_in,
   output logic              sdata,
   output logic              bclk_out,
   output logic              lrclk_out
);
   spdx_pkg::spdx_ser_t r;
   spdx_pkg::spdx_ser_t next_r;
   logic                bclk_fall;
   logic                frame_start;

   // Both clocks cross through two flops; only the second stage feeds edge detection.
   always_comb begin
      next_r = r;
      next_r.bclk_s1 = bclk_in;
      next_r.bclk_s2 = r.bclk_s1;
      next_r.bclk_d = r.bclk_s2;
      next_r.lr_s1 = lrclk_in;
      next_r.lr_s2 = r.lr_s1;
      bclk_fall = r.bclk_d & ~r.bclk_s2;
      frame_start = r.lr_s2 & ~r.lr_d;
      // Data changes on the falling bit clock so the far end samples it on the rising one.
      if (bclk_fall) begin
         next_r.lr_d = r.lr_s2;
         if (frame_start) begin
            next_r.frame = frame_in; // Frame content is frozen for the whole frame. [R10]
            next_r.idx = `SPDX_IDX_ONE;
            next_r.sdata = enable & frame_in[`SPDX_FRAME_TOP]; // [R20]
         end else begin
            next_r.sdata = enable & r.frame[`SPDX_FRAME_TOP - r.idx]; // Most significant first. [R20]
            next_r.idx = r.idx + `SPDX_IDX_ONE;
         end
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign sdata = r.sdata;
   assign bclk_out = r.bclk_s2;
   assign lrclk_out = r.lr_s2;

   property p_ser_first;
      @(posedge pclk) disable iff (!presetn)
      (bclk_fall && frame_start) |=> (sdata == $past(enable & frame_in[255]) && r.idx == 8'h01);
   endproperty
   a_ser_first: assert property (p_ser_first) else $error("First stream bit is not frame bit 255."); // [R20]

   property p_ser_hold;
      @(posedge pclk) disable iff (!presetn)
      !bclk_fall |=> $stable(sdata) && $stable(r.idx);
   endproperty
   a_ser_hold: assert property (p_ser_hold) else $error("Stream bit moved without a bit clock fall."); // [R10]
endmodule // spdx_slot_ser

/* logic/spdx_rx_ctrl.sv */
// Receiver lock, mute and resume control, clock speed selects and auxiliary stream output.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "spdx_regs.svh"

// Behaviour
// [R01] Lock_lost_flag mutes audio at once.
// [R02] Auto-resume set: relock resumes audio itself.
// [R03] Otherwise software restarts with 0, 1, 0.
// [R04] Writing auto-resume one clears loss flag.
// [R05] Loss after lock sets flag, sticky.
// [R06] Loss flag read-only, resets to zero.
// [R07] Software may clear auto-resume afterwards.
// [R08] Receiver clock select: 0 full, 1 half.
// [R09] Transmitter clock select: 0 full, 1 half.
// [R10] Enabled output carries eight-slot stream.
// [R11] Slot 0: left audio, eight zeros.
// [R12] Slot 1: zeros, left aux bits, zeros.
// [R13] Slot 2: zeros, compression, audio type, zeros.
// [R14] Slots 3 and 6 all zero.
// [R15] Slot 4: right audio, eight zeros.
// [R16] Slot 5: zeros, right aux bits, zeros.
// [R17] Slot 7: zeros, block start, zeros.
// [R18] One-hot select picks port; zero disables.
// [R19] Selected port is clock master, source selectable.
// [R20] Slot bits leave most significant first.
module spdx_rx_ctrl (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [17:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        rx_locked,
   input  wire logic [23:0] audio_left,
   input  wire logic [23:0] audio_right,
   input  wire logic [3:0]  aux_left,
   input  wire logic [3:0]  aux_right,
   input  wire logic        compr_type,
   input  wire logic        audio_type,
   input  wire logic        block_start,
   input  wire logic        rx_bclk,
   input  wire logic        rx_lrclk,
   input  wire logic        gen3_bclk,
   input  wire logic        gen3_lrclk,
   output logic             audio_muted,
   output logic             rx_mclk_tick,
   output logic             tx_mclk_tick,
   output logic [3:0]       serial_out_pin,
   output logic [3:0]       port_bclk,
   output logic [3:0]       port_lrclk
);
   spdx_pkg::spdx_ctrl_t r;
   spdx_pkg::spdx_ctrl_t next_r;
   logic [15:0]  reg_idx;
   logic         access;
   logic         wr_done;
   logic         wr_ok;
   logic         hit;
   logic [15:0]  rd_val;
   logic         loss_event;
   logic         clear_flag;
   logic         manual_restart;
   logic         sel_legal;
   logic         ser_en;
   logic [23:0]  left_gated;
   logic [23:0]  right_gated;
   logic [255:0] frame;
   logic         bclk_pick;
   logic         lrclk_pick;
   logic         ser_sdata;
   logic         ser_bclk;
   logic         ser_lrclk;

   // APB decode; the access phase always takes one wait state before pready.
   assign reg_idx = paddr[17:2];
   assign access = psel & penable;
   assign wr_done = access & pwrite & r.pready;
   assign wr_ok = wr_done & pstrb[`SPDX_STRB_LO];

   // Reserved bits read as zero; an unmapped index answers with pslverr.
   always_comb begin
      hit = 1'b1;
      rd_val = `SPDX_ZERO16;
      unique case (reg_idx)
         `SPDX_IDX_RESTART: rd_val[`SPDX_CTL_BIT] = r.auto_resume;
         `SPDX_IDX_LOSS:    rd_val[`SPDX_CTL_BIT] = r.lock_lost_flag; // [R06]
         `SPDX_IDX_RXSPD:   rd_val[`SPDX_CTL_BIT] = r.rx_clk_div_sel;
         `SPDX_IDX_TXSPD:   rd_val[`SPDX_CTL_BIT] = r.tx_clk_div_sel;
         `SPDX_IDX_AUXEN: begin
            rd_val[`SPDX_SEL_HI:`SPDX_SEL_LO] = r.aux_port_select;
            rd_val[`SPDX_CLKSRC_BIT] = r.aux_port_clk_source;
         end
         default:           hit = 1'b0;
      endcase
   end

   // Lock events: a loss only counts once lock had been acquired and audio was playing.
   assign loss_event = (r.st == spdx_pkg::SPDX_PLAY) & ~rx_locked; // [R05]
   assign clear_flag = wr_ok & (reg_idx == `SPDX_IDX_RESTART) & pwdata[`SPDX_CTL_BIT]; // [R04]
   // Returning the bit from one to zero is the manual restart stroke.
   assign manual_restart = wr_ok & (reg_idx == `SPDX_IDX_RESTART) & r.auto_resume
                         & ~pwdata[`SPDX_CTL_BIT]; // [R03] [R07]

   // Only the four one-hot codes drive a port; anything else is treated as off.
   assign sel_legal = (r.aux_port_select == `SPDX_PORT0) | (r.aux_port_select == `SPDX_PORT1)
                    | (r.aux_port_select == `SPDX_PORT2) | (r.aux_port_select == `SPDX_PORT3); // [R18]
   assign ser_en = sel_legal;

   // Muted audio still lets the auxiliary bits through, so status stays visible downstream.
   assign left_gated = r.muted ? '0 : audio_left; // [R01]
   assign right_gated = r.muted ? '0 : audio_right; // [R01]
   assign frame = {left_gated, `SPDX_PAD8,                              // [R11]
                   `SPDX_Z20, aux_left, `SPDX_PAD8,                      // [R12]
                   `SPDX_Z22, compr_type, audio_type, `SPDX_PAD8,        // [R13]
                   `SPDX_Z32,                                            // [R14]
                   right_gated, `SPDX_PAD8,                              // [R15]
                   `SPDX_Z20, aux_right, `SPDX_PAD8,                     // [R16]
                   `SPDX_Z32,                                            // [R14]
                   `SPDX_Z23, block_start, `SPDX_PAD8};                  // [R17]

   // Clock source for the master port; the mux sits ahead of the synchroniser.
   assign bclk_pick = r.aux_port_clk_source ? gen3_bclk : rx_bclk; // [R19]
   assign lrclk_pick = r.aux_port_clk_source ? gen3_lrclk : rx_lrclk; // [R19]

   spdx_slot_ser u_ser (
      .pclk     (pclk),
      .presetn  (presetn),
      .bclk_in  (bclk_pick),
      .lrclk_in (lrclk_pick),
      .enable   (ser_en),
      .frame_in (frame),
      .sdata    (ser_sdata),
      .bclk_out (ser_bclk),
      .lrclk_out(ser_lrclk)
   );

   // Next-state logic for every register of the block.
   always_comb begin
      next_r = r;
      // Bus answer.
      next_r.pready = access & ~r.pready;
      if (access & ~r.pready) begin
         next_r.prdata = (pwrite | ~hit) ? `SPDX_ZERO16 : rd_val;
         next_r.pslverr = ~hit;
      end
      // Register writes take effect at the completing edge.
      if (wr_ok) begin
         unique case (reg_idx)
            `SPDX_IDX_RESTART: next_r.auto_resume = pwdata[`SPDX_CTL_BIT];
            `SPDX_IDX_RXSPD:   next_r.rx_clk_div_sel = pwdata[`SPDX_CTL_BIT];
            `SPDX_IDX_TXSPD:   next_r.tx_clk_div_sel = pwdata[`SPDX_CTL_BIT];
            `SPDX_IDX_AUXEN: begin
               next_r.aux_port_select = pwdata[`SPDX_SEL_HI:`SPDX_SEL_LO];
               next_r.aux_port_clk_source = pwdata[`SPDX_CLKSRC_BIT];
            end
            default:           next_r.auto_resume = r.auto_resume;
         endcase
      end
      // Sticky flag: a loss in the same cycle as the clearing write wins.
      if (loss_event) begin
         next_r.lock_lost_flag = 1'b1; // [R05]
      end else if (clear_flag) begin
         next_r.lock_lost_flag = 1'b0; // [R04]
      end
      // Lock state machine.
      unique case (r.st)
         spdx_pkg::SPDX_ACQUIRE: begin
            if (rx_locked) begin
               next_r.st = spdx_pkg::SPDX_PLAY;
            end
         end
         spdx_pkg::SPDX_PLAY: begin
            if (!rx_locked) begin
               next_r.st = spdx_pkg::SPDX_MUTED; // [R01]
            end
         end
         spdx_pkg::SPDX_MUTED: begin
            if (rx_locked & r.auto_resume) begin
               next_r.st = spdx_pkg::SPDX_PLAY; // [R02]
            end else if (manual_restart) begin
               next_r.st = spdx_pkg::SPDX_ACQUIRE; // [R03]
            end
         end
      endcase
      next_r.muted = (next_r.st != spdx_pkg::SPDX_PLAY); // [R01]
      // Speed ticks: every cycle at full rate, every other cycle at half rate.
      next_r.div_phase = ~r.div_phase;
      next_r.rx_tick = r.rx_clk_div_sel ? r.div_phase : 1'b1; // [R08]
      next_r.tx_tick = r.tx_clk_div_sel ? r.div_phase : 1'b1; // [R09]
      // Port outputs; unselected ports hold low.
      for (int i = 0; i < 4; i++) begin
         next_r.serial_out[i] = sel_legal & r.aux_port_select[i] & ser_sdata; // [R18]
         next_r.bclk_out[i] = sel_legal & r.aux_port_select[i] & ser_bclk; // [R19]
         next_r.lrclk_out[i] = sel_legal & r.aux_port_select[i] & ser_lrclk; // [R19]
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.st <= spdx_pkg::SPDX_ACQUIRE;
         r.auto_resume <= `SPDX_RST_RESUME;
         r.rx_clk_div_sel <= `SPDX_RST_RXSPD; // [R08]
         r.tx_clk_div_sel <= `SPDX_RST_TXSPD; // [R09]
         r.aux_port_select <= `SPDX_RST_SEL;
         r.aux_port_clk_source <= `SPDX_RST_CLKSRC;
         r.muted <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign pready = r.pready;
   assign prdata = {`SPDX_ZERO16, r.prdata};
   assign pslverr = r.pslverr;
   assign audio_muted = r.muted;
   assign rx_mclk_tick = r.rx_tick;
   assign tx_mclk_tick = r.tx_tick;
   assign serial_out_pin = r.serial_out;
   assign port_bclk = r.bclk_out;
   assign port_lrclk = r.lrclk_out;

   property p_mute_on_loss;
      @(posedge pclk) disable iff (!presetn)
      (r.st == spdx_pkg::SPDX_PLAY && !rx_locked) |=> (audio_muted && r.st == spdx_pkg::SPDX_MUTED);
   endproperty
   a_mute_on_loss: assert property (p_mute_on_loss) else $error("Lock loss did not mute."); // [R01]

   property p_auto_resume;
      @(posedge pclk) disable iff (!presetn)
      (r.st == spdx_pkg::SPDX_MUTED && rx_locked && r.auto_resume) |=> !audio_muted;
   endproperty
   a_auto_resume: assert property (p_auto_resume) else $error("Relock with auto-resume stayed muted."); // [R02]

   property p_stay_muted;
      @(posedge pclk) disable iff (!presetn)
      (r.st == spdx_pkg::SPDX_MUTED && !r.auto_resume) |=> audio_muted;
   endproperty
   a_stay_muted: assert property (p_stay_muted) else $error("Resumed without auto-resume or restart."); // [R03]

   property p_flag_clear;
      @(posedge pclk) disable iff (!presetn)
      (clear_flag && !loss_event) |=> !r.lock_lost_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("Auto-resume write left loss flag set."); // [R04]

   property p_flag_sticky;
      @(posedge pclk) disable iff (!presetn)
      (r.lock_lost_flag && !clear_flag) |=> r.lock_lost_flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("Loss flag dropped without clearing write."); // [R05]

   property p_flag_read;
      @(posedge pclk) disable iff (!presetn)
      (access && !pwrite && pready && reg_idx == `SPDX_IDX_LOSS) |-> prdata == {31'h0, $past(r.lock_lost_flag)};
   endproperty
   a_flag_read: assert property (p_flag_read) else $error("Loss flag read value wrong."); // [R06]

   property p_rx_full;
      @(posedge pclk) disable iff (!presetn)
      !r.rx_clk_div_sel |=> rx_mclk_tick;
   endproperty
   a_rx_full: assert property (p_rx_full) else $error("Receiver full-rate tick missing."); // [R08]

   property p_tx_half;
      @(posedge pclk) disable iff (!presetn)
      (r.tx_clk_div_sel && $past(r.tx_clk_div_sel) && tx_mclk_tick) |=> !tx_mclk_tick;
   endproperty
   a_tx_half: assert property (p_tx_half) else $error("Transmitter half-rate tick not alternating."); // [R09]

   property p_port_off;
      @(posedge pclk) disable iff (!presetn)
      (r.aux_port_select == 4'h0) |=> (serial_out_pin == 4'h0 && port_bclk == 4'h0);
   endproperty
   a_port_off: assert property (p_port_off) else $error("Disabled output still active."); // [R18]

   property p_port_route;
      @(posedge pclk) disable iff (!presetn)
      sel_legal |=> serial_out_pin == ($past(r.aux_port_select) & {4{$past(ser_sdata)}});
   endproperty
   a_port_route: assert property (p_port_route) else $error("Stream not on selected port."); // [R10]
endmodule // spdx_rx_ctrl

/* tb/spdx_src_model.sv */
// Behavioural S/PDIF source: lock level, decoded data words and free-running recovered clocks.
`timescale 1ns/10ps

module spdx_src_model #(
   parameter real         HALF_NS = 41.3,
   parameter logic [23:0] LEFT    = 24'h000000,
   parameter logic [23:0] RIGHT   = 24'h000000,
   parameter logic [3:0]  AUXL    = 4'h0,
   parameter logic [3:0]  AUXR    = 4'h0,
   parameter logic        COMPR   = 1'b0,
   parameter logic        ATYPE   = 1'b0,
   parameter logic        BSTART  = 1'b0
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        lock_req,
   output logic             rx_locked,
   output logic             bclk,
   output logic             lrclk,
   output logic [23:0]      audio_left,
   output logic [23:0]      audio_right,
   output logic [3:0]       aux_left,
   output logic [3:0]       aux_right,
   output logic             compr_type,
   output logic             audio_type,
   output logic             block_start
);
   logic [7:0] bit_cnt;

   // Recovered clocks run free; their period is unrelated in phase to the system clock.
   initial begin
      bclk = 1'b0;
      forever #(HALF_NS) bclk = ~bclk;
   end

   // The frame clock rises with bit 0 and stays high for half of the 256-bit frame.
   always @(posedge bclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt <= 8'h00;
         lrclk   <= 1'b0;
      end else begin
         bit_cnt <= bit_cnt + 8'h01;
         lrclk   <= (bit_cnt < 8'h80);
      end
   end

   // Lock follows the request one system clock later, as a real receiver would lag.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_locked <= 1'b0;
      end else begin
         rx_locked <= lock_req;
      end
   end

   // Decoded words are held constant so every frame is predictable.
   assign audio_left  = LEFT;
   assign audio_right = RIGHT;
   assign aux_left    = AUXL;
   assign aux_right   = AUXR;
   assign compr_type  = COMPR;
   assign audio_type  = ATYPE;
   assign block_start = BSTART;
endmodule // spdx_src_model

/* tb/tb.sv */
// Self-checking bench for the receiver control block and its eight-slot output.
`timescale 1ns/10ps
`include "spdx_regs.svh"

module tb;
   localparam logic [23:0] LEFT  = 24'hc35a17;
   localparam logic [23:0] RIGHT = 24'h3ca5e8;
   localparam logic [3:0]  AUXL  = 4'ha;
   localparam logic [3:0]  AUXR  = 4'h5;
   localparam int          LIMIT = 80000;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, lock_req, rx_locked;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb, aux_left, aux_right, serial_out_pin, port_bclk, port_lrclk;
   logic [23:0] audio_left, audio_right;
   logic        compr_type, audio_type, block_start, rx_bclk, rx_lrclk, gen3_bclk, gen3_lrclk;
   logic        audio_muted, rx_tick, tx_tick;
   int          failures, total_checks, cycles;

   spdx_rx_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .rx_locked(rx_locked), .audio_left(audio_left), .audio_right(audio_right), .aux_left(aux_left),
      .aux_right(aux_right), .compr_type(compr_type), .audio_type(audio_type), .block_start(block_start),
      .rx_bclk(rx_bclk), .rx_lrclk(rx_lrclk), .gen3_bclk(gen3_bclk), .gen3_lrclk(gen3_lrclk),
      .audio_muted(audio_muted), .rx_mclk_tick(rx_tick), .tx_mclk_tick(tx_tick),
      .serial_out_pin(serial_out_pin), .port_bclk(port_bclk), .port_lrclk(port_lrclk));

   spdx_src_model #(.HALF_NS(41.3), .LEFT(LEFT), .RIGHT(RIGHT), .AUXL(AUXL), .AUXR(AUXR), .COMPR(1'b1),
      .ATYPE(1'b0), .BSTART(1'b1)) src (.pclk(pclk), .presetn(presetn), .lock_req(lock_req),
      .rx_locked(rx_locked), .bclk(rx_bclk), .lrclk(rx_lrclk), .audio_left(audio_left),
      .audio_right(audio_right), .aux_left(aux_left), .aux_right(aux_right), .compr_type(compr_type),
      .audio_type(audio_type), .block_start(block_start));

   // A second source stands in for the third clock generator; only its clocks are used.
   spdx_src_model #(.HALF_NS(57.7)) gen3 (.pclk(pclk), .presetn(presetn), .lock_req(1'b0), .rx_locked(),
      .bclk(gen3_bclk), .lrclk(gen3_lrclk), .audio_left(), .audio_right(), .aux_left(), .aux_right(),
      .compr_type(), .audio_type(), .block_start());

   // System clock at 200 MHz.
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Watchdog: a hang counts as a mismatch and still reaches the closing report.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         end_of_test();
      end
   end

   task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer; the request is held until pready is sampled high or 16 edges have passed.
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= {16'h0000, wd};
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [15:0] idx, input logic [15:0] wd);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, idx, wd, rd, err);
      check("write_err", err, 1'b0);
   endtask

   task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp, input string what);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, idx, 16'h0000, rd, err);
      check(what, rd, exp);
   endtask

   // Waits a bounded number of edges for the mute level, then judges it.
   task automatic wait_mute(input logic exp, input int lim);
      int n;
      n = 0;
      while (audio_muted !== exp && n < lim) begin
         @(posedge pclk);
         n++;
      end
      check("audio_muted", audio_muted, exp);
   endtask

   task automatic t_reset();
      logic [31:0] rd;
      logic        err;
      check("muted_after_reset", audio_muted, 1'b1);
      rd_chk(`SPDX_IDX_RESTART, 32'h00000000, "auto_resume_ctrl");
      rd_chk(`SPDX_IDX_LOSS, 32'h00000000, "lock_lost_status");
      rd_chk(`SPDX_IDX_RXSPD, 32'h00000001, "rx_clock_speed_sel");
      rd_chk(`SPDX_IDX_TXSPD, 32'h00000001, "tx_clock_speed_sel");
      rd_chk(`SPDX_IDX_AUXEN, 32'h00000000, "aux_output_enable");
      apb(1'b0, 16'hf60f, 16'h0000, rd, err);
      check("unmapped_err", err, 1'b1);
      check("unmapped_data", rd, 32'h00000000);
      $display("test reset done");
   endtask

   // Full rate ticks every cycle, half rate every other cycle; ends back at the reset value.
   task automatic t_ticks();
      int nr, nt;
      for (int s = 0; s < 2; s++) begin
         wr(`SPDX_IDX_RXSPD, 16'(s));
         wr(`SPDX_IDX_TXSPD, 16'(s));
         nr = 0;
         nt = 0;
         repeat (8) begin
            @(posedge pclk);
            nr += int'(rx_tick);
            nt += int'(tx_tick);
         end
         check("rx_tick_count", nr, (s == 0) ? 8 : 4);
         check("tx_tick_count", nt, (s == 0) ? 8 : 4);
      end
      $display("test ticks done");
   endtask

   task automatic t_lock();
      lock_req <= 1'b1;
      wait_mute(1'b0, 6);
      rd_chk(`SPDX_IDX_LOSS, 32'h00000000, "flag_locked");
      lock_req <= 1'b0;
      wait_mute(1'b1, 4);
      rd_chk(`SPDX_IDX_LOSS, 32'h00000001, "flag_set");
      wr(`SPDX_IDX_LOSS, 16'h0000);
      rd_chk(`SPDX_IDX_LOSS, 32'h00000001, "flag_read_only");
      lock_req <= 1'b1;
      repeat (10) @(posedge pclk);
      check("no_resume", audio_muted, 1'b1);
      wr(`SPDX_IDX_RESTART, 16'h0001);
      rd_chk(`SPDX_IDX_LOSS, 32'h00000000, "flag_cleared");
      wait_mute(1'b0, 6);
      wr(`SPDX_IDX_RESTART, 16'h0000);
      rd_chk(`SPDX_IDX_LOSS, 32'h00000000, "flag_stays_clear");
      $display("test lock done");
   endtask

   // Captures one frame per port at the port's own bit clock and checks the idle ports.
   task automatic t_stream();
      logic [255:0] exp, seen;
      logic [3:0]   code, stray;
      exp = {LEFT, 8'h00, 20'h00000, AUXL, 8'h00, 22'h000000, 1'b1, 1'b0, 8'h00, 32'h00000000,
             RIGHT, 8'h00, 20'h00000, AUXR, 8'h00, 32'h00000000, 23'h000000, 1'b1, 8'h00};
      for (int k = 0; k < 4; k++) begin
         code = 4'h1 << k;
         wr(`SPDX_IDX_AUXEN, {11'h000, k[0], code});
         // Selecting a port while the frame clock is high looks like a rise, so wait for a real low first.
         @(negedge port_lrclk[k]);
         @(posedge port_lrclk[k]);
         @(negedge port_bclk[k]);
         stray = 4'h0;
         for (int b = 255; b >= 0; b--) begin
            @(posedge port_bclk[k]);
            seen[b] = serial_out_pin[k];
            stray |= (serial_out_pin | port_bclk | port_lrclk) & ~code;
         end
         check("frame", seen, exp);
         check("idle_ports", stray, 4'h0);
         @(posedge pclk);
      end
      for (int m = 0; m < 2; m++) begin
         wr(`SPDX_IDX_AUXEN, (m == 0) ? 16'h0003 : 16'h0000);
         stray = 4'h0;
         repeat (300) begin
            @(posedge pclk);
            stray |= serial_out_pin | port_bclk | port_lrclk;
         end
         check("disabled_ports", stray, 4'h0);
      end
      $display("test stream done");
   endtask

   initial begin
      presetn  = 1'b0;
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 18'h00000;
      pwdata   = 32'h00000000;
      pstrb    = 4'hf;
      lock_req = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_ticks();
      t_lock();
      t_stream();
      end_of_test();
   end
endmodule // tb
